// File: rtl/tmrm_pkg.sv
// Package of offsets, field positions and reset values for the thermal monitor register bank.
`default_nettype none
package tmrm_pkg;
  // Read addresses of the pointer-addressed register map.
  localparam logic [7:0] RD_LVAL = 8'h00;
  localparam logic [7:0] RD_RSEL_VHI = 8'h01;
  localparam logic [7:0] RD_STAT1 = 8'h02;
  localparam logic [7:0] RD_CFG1 = 8'h03;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] RD_LHI = 8'h05;
  localparam logic [7:0] RD_LLO = 8'h06;
  localparam logic [7:0] RD_RSEL_HLH = 8'h07;
  localparam logic [7:0] RD_RSEL_LLH = 8'h08;
  localparam logic [7:0] RD_RSEL_VLO = 8'h10;
  localparam logic [7:0] RD_STAT2 = 8'h23;
  localparam logic [7:0] RD_R2_VHI = 8'h30;
  localparam logic [7:0] RD_R2_VLO = 8'h33;
  localparam logic [7:0] RD_MAKER = 8'hfe;
  localparam logic [7:0] RD_SREV = 8'hff;
  // Write addresses that differ from the read addresses.
  localparam logic [7:0] WR_CFG1 = 8'h09;
  localparam logic [7:0] WR_RATE = 8'h0a;
  localparam logic [7:0] WR_LHI = 8'h0b;
  localparam logic [7:0] WR_LLO = 8'h0c;
  localparam logic [7:0] WR_RSEL_HLH = 8'h0d;
  localparam logic [7:0] WR_RSEL_LLH = 8'h0e;
  localparam logic [7:0] WR_ONESHOT = 8'h0f;
  // Addresses shared by read and write.
  localparam logic [7:0] RW_RSEL_OFH = 8'h11;
  localparam logic [7:0] RW_RSEL_OFL = 8'h12;
  localparam logic [7:0] RW_RSEL_HLL = 8'h13;
  localparam logic [7:0] RW_RSEL_LLL = 8'h14;
  localparam logic [7:0] RW_RSEL_THM = 8'h19;
  localparam logic [7:0] RW_LTHM = 8'h20;
  localparam logic [7:0] RW_HYST = 8'h21;
  localparam logic [7:0] RW_FILT = 8'h22;
  localparam logic [7:0] RW_CFG2 = 8'h24;
  localparam logic [7:0] RW_R2_HLH = 8'h31;
  localparam logic [7:0] RW_R2_LLH = 8'h32;
  localparam logic [7:0] RW_R2_OFH = 8'h34;
  localparam logic [7:0] RW_R2_OFL = 8'h35;
  localparam logic [7:0] RW_R2_HLL = 8'h36;
  localparam logic [7:0] RW_R2_LLL = 8'h37;
  localparam logic [7:0] RW_R2_THM = 8'h39;
  // Slots of the general register array.
  localparam int G_CFG1 = 0;
  localparam int G_RATE = 1;
  localparam int G_LHI = 2;
  localparam int G_LLO = 3;
  localparam int G_LTHM = 4;
  localparam int G_HYST = 5;
  localparam int G_FILT = 6;
  localparam int G_CFG2 = 7;
  localparam int G_LVAL = 8;
  localparam int NGEN = 9;
  // Slots of each remote channel array.
  localparam int R_VHI = 0;
  localparam int R_VLO = 1;
  localparam int R_HLH = 2;
  localparam int R_LLH = 3;
  localparam int R_OFH = 4;
  localparam int R_OFL = 5;
  localparam int R_HLL = 6;
  localparam int R_LLL = 7;
  localparam int R_THM = 8;
  localparam int NREM = 9;
  // Power-on values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_HIGH = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam logic [7:0] RST_RATE = 8'h07;
  localparam logic [7:0] RST_FILT = 8'h01;
  // Field positions.
  localparam int CFG1_RSEL_BIT = 3;
  localparam int CFG1_STBY_BIT = 6;
  localparam int FILT_SCL_BIT = 7;
  localparam int FILT_SDA_BIT = 6;
  localparam int FILT_MASK_BIT = 5;
  localparam int FILT_CNT_LSB = 1;
  localparam int FILT_CNT_W = 3;
  // Bus timeout, in microseconds, at a 100 ns clock.
  localparam int CLK_NS = 100;
  localparam int TIMEOUT_US = 25000;
  localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_NS;
endpackage : tmrm_pkg
`default_nettype wire

// File: rtl/tmrm_regbank.sv
// Register bank, consecutive limit filter, one-shot strobe and bus timeout of the monitor.
`default_nettype none

// Operation
// RULE1: One-shot write in standby starts one conversion.
// RULE2: Write itself triggers; data byte is discarded.
// RULE3: Limit output waits for coded violation count.
// RULE4: Power-on filter needs one violation.
// RULE5: At most four violations selectable.
// RULE6: Top filter bits enable clock, data timeouts.
// RULE7: Next filter bit masks local channel alerts.
// RULE8: Split read and write addresses, host matches.
// RULE9: Shared remote addresses follow channel-select bit.
// RULE10: Second remote also at dedicated addresses.
// RULE11: Power-on defaults for limits, hysteresis, rate.
// RULE12: Select bit three also steers offset access.
// RULE13: Enabled timeout abandons stalled transaction.
// RULE14: Unmasked set flags latch active-low alert.
// RULE15: In-limit measurement restarts violation count.
// RULE16: Lock blocks host writes, not value updates.
module tmrm_regbank
  import tmrm_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
  parameter logic [7:0] SILICON_REV = 8'h01 // Arbitrary value.
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ptr_we,
  input wire logic [7:0] ptr_wdata,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  input wire logic lock,
  input wire logic meas_we,
  input wire logic [1:0] meas_chan,
  input wire logic [7:0] meas_hi,
  input wire logic [7:0] meas_lo,
  input wire logic meas_oor,
  input wire logic [7:0] status1_flags,
  input wire logic alert_serviced,
  input wire logic bus_busy,
  input wire logic scl_low,
  input wire logic sda_low,
  output logic bus_abort,
  output logic oneshot_start,
  output logic alert_n,
  output logic standby,
  output logic [7:0] conv_rate
);

  ////////////////////////////////////////////////////////////////////////////
  // State and types.

  localparam int NCH = 3; // Local, first remote, second remote.
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  // Result of decoding the pointer for one access direction.
  typedef struct packed {
    logic hit;
    logic rem;
    logic ch;
    logic [3:0] idx;
  } tmrm_dec_s;

  // Whole state of the bank.
  typedef struct packed {
    logic [7:0] ptr;
    logic [NGEN-1:0][7:0] gen;
    logic [1:0][NREM-1:0][7:0] rem;
    logic [NCH-1:0][2:0] cnt;
    logic alert;
    logic [TW-1:0] tmo;
    logic abort;
    logic shot;
    logic [7:0] rdat;
  } tmrm_state_s;

  tmrm_state_s st_r;
  tmrm_state_s st_nxt;

  // Maps a pointer to a storage slot; wr selects the write map.
  function automatic tmrm_dec_s decode(input logic [7:0] a, input logic wr,
                                       input logic sel);
    tmrm_dec_s d;
    d = '0;
    d.hit = 1'b1;
    d.ch = sel; // RULE9 RULE12
    case (a)
      RD_LVAL: begin d.hit = !wr; d.idx = 4'(G_LVAL); end
      RD_RSEL_VHI: begin d.hit = !wr; d.rem = 1'b1; d.idx = 4'(R_VHI); end
      RD_RSEL_VLO: begin d.hit = !wr; d.rem = 1'b1; d.idx = 4'(R_VLO); end
      RD_CFG1: begin d.hit = !wr; d.idx = 4'(G_CFG1); end // RULE8
      RD_RATE: begin d.hit = !wr; d.idx = 4'(G_RATE); end // RULE8
      RD_LHI: begin d.hit = !wr; d.idx = 4'(G_LHI); end // RULE8
      RD_LLO: begin d.hit = !wr; d.idx = 4'(G_LLO); end // RULE8
      RD_RSEL_HLH: begin d.hit = !wr; d.rem = 1'b1; d.idx = 4'(R_HLH); end
      RD_RSEL_LLH: begin d.hit = !wr; d.rem = 1'b1; d.idx = 4'(R_LLH); end
      WR_CFG1: begin d.hit = wr; d.idx = 4'(G_CFG1); end // RULE8
      WR_RATE: begin d.hit = wr; d.idx = 4'(G_RATE); end // RULE8
      WR_LHI: begin d.hit = wr; d.idx = 4'(G_LHI); end // RULE8
      WR_LLO: begin d.hit = wr; d.idx = 4'(G_LLO); end // RULE8
      WR_RSEL_HLH: begin d.hit = wr; d.rem = 1'b1; d.idx = 4'(R_HLH); end
      WR_RSEL_LLH: begin d.hit = wr; d.rem = 1'b1; d.idx = 4'(R_LLH); end
      RW_RSEL_OFH: begin d.rem = 1'b1; d.idx = 4'(R_OFH); end
      RW_RSEL_OFL: begin d.rem = 1'b1; d.idx = 4'(R_OFL); end
      RW_RSEL_HLL: begin d.rem = 1'b1; d.idx = 4'(R_HLL); end
      RW_RSEL_LLL: begin d.rem = 1'b1; d.idx = 4'(R_LLL); end
      RW_RSEL_THM: begin d.rem = 1'b1; d.idx = 4'(R_THM); end
      RW_LTHM: d.idx = 4'(G_LTHM);
      RW_HYST: d.idx = 4'(G_HYST);
      RW_FILT: d.idx = 4'(G_FILT);
      RW_CFG2: d.idx = 4'(G_CFG2);
      // Dedicated second-remote addresses ignore the select bit.
      RD_R2_VHI: begin d.hit = !wr; d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_VHI); end // RULE10
      RD_R2_VLO: begin d.hit = !wr; d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_VLO); end // RULE10
      RW_R2_HLH: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_HLH); end // RULE10
      RW_R2_LLH: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_LLH); end // RULE10
      RW_R2_OFH: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_OFH); end // RULE10
      RW_R2_OFL: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_OFL); end // RULE10
      RW_R2_HLL: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_HLL); end // RULE10
      RW_R2_LLL: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_LLL); end // RULE10
      RW_R2_THM: begin d.rem = 1'b1; d.ch = 1'b1; d.idx = 4'(R_THM); end // RULE10
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers.

  tmrm_dec_s wdec; // Decoded write target.
  tmrm_dec_s rdec; // Decoded read source.
  logic [2:0] need; // Violations required, one to four.
  logic [NCH-1:0] tripped; // Channel has reached its required count.
  logic stall; // An enabled line is held low while the bus is busy.

  // Decode both directions with the current channel select.
  always_comb begin
    wdec = decode(st_r.ptr, 1'b1, st_r.gen[G_CFG1][CFG1_RSEL_BIT]);
    rdec = decode(st_r.ptr, 1'b0, st_r.gen[G_CFG1][CFG1_RSEL_BIT]);
  end

  // The thermometer code gives the count; other codes count their set bits in bits 1 to 3, and bit 0 is ignored.
  always_comb begin
    need = 3'(1) + 3'($countones(st_r.gen[G_FILT][FILT_CNT_LSB +: FILT_CNT_W])); // RULE3 RULE5
  end

  // Each channel is tripped once its run of violations meets the need.
  for (genvar c = 0; c < NCH; c++) begin : g_trip
    assign tripped[c] = st_r.cnt[c] >= need; // RULE3
  end

  // Timeout watches a stuck line only while its enable is set.
  always_comb begin
    stall = bus_busy && ((st_r.gen[G_FILT][FILT_SCL_BIT] && scl_low) ||
                         (st_r.gen[G_FILT][FILT_SDA_BIT] && sda_low)); // RULE6 RULE13
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Computes every register update for the coming edge.
  always_comb begin
    logic raise;
    raise = 1'b0;
    st_nxt = st_r;
    st_nxt.shot = 1'b0;
    st_nxt.abort = 1'b0;
    // The first byte of a write loads the pointer.
    if (ptr_we) begin
      st_nxt.ptr = ptr_wdata;
    end
    // Data writes go to the decoded slot unless locked; strobe data is dropped.
    if (data_we) begin
      if (st_r.ptr == WR_ONESHOT) begin
        st_nxt.shot = st_r.gen[G_CFG1][CFG1_STBY_BIT]; // RULE1 RULE2
      end else if (wdec.hit && !lock) begin // RULE16
        if (wdec.rem) begin
          st_nxt.rem[wdec.ch][wdec.idx] = wdata; // RULE9 RULE10
        end else begin
          st_nxt.gen[wdec.idx] = wdata; // RULE8
        end
      end
    end
    // Reads capture the decoded byte; unmapped addresses read zero.
    if (rd_req) begin
      if (rdec.hit && rdec.rem) begin
        st_nxt.rdat = st_r.rem[rdec.ch][rdec.idx];
      end else if (rdec.hit) begin
        st_nxt.rdat = st_r.gen[rdec.idx];
      end else if (st_r.ptr == RD_STAT1) begin
        st_nxt.rdat = status1_flags;
      end else if (st_r.ptr == RD_STAT2) begin
        st_nxt.rdat = {7'h00, st_r.alert};
      end else if (st_r.ptr == RD_MAKER) begin
        st_nxt.rdat = MAKER_ID;
      end else if (st_r.ptr == RD_SREV) begin
        st_nxt.rdat = SILICON_REV;
      end else begin
        st_nxt.rdat = RST_ZERO;
      end
    end
    // Measurements update value registers even under lock.
    if (meas_we) begin
      if (meas_chan == 2'd0) begin
        st_nxt.gen[G_LVAL] = meas_hi; // RULE16
      end else begin
        st_nxt.rem[meas_chan == 2'd2][R_VHI] = meas_hi; // RULE16
        st_nxt.rem[meas_chan == 2'd2][R_VLO] = meas_lo;
      end
      // Count consecutive violations, saturating at four.
      if (meas_chan < 2'(NCH)) begin
        if (!meas_oor) begin
          st_nxt.cnt[meas_chan] = 3'd0; // RULE15
        end else if (st_r.cnt[meas_chan] < 3'd4) begin
          st_nxt.cnt[meas_chan] = st_r.cnt[meas_chan] + 3'd1; // RULE3 RULE5
        end
        // Raise the latch on the measurement that meets the need.
        raise = meas_oor && ((st_r.cnt[meas_chan] + 3'd1) >= need) &&
                !(meas_chan == 2'd0 && st_r.gen[G_FILT][FILT_MASK_BIT]); // RULE3 RULE7
      end
    end
    // Servicing clears the latch once no channel is tripped; a set wins.
    if (raise) begin
      st_nxt.alert = 1'b1; // RULE14
    end else if (alert_serviced && tripped == '0) begin
      st_nxt.alert = 1'b0;
    end
    // Timeout counter runs while the stall persists and fires once every TIMEOUT_CYCLES cycles of stall.
    if (!stall) begin
      st_nxt.tmo = '0;
    end else if (st_r.tmo == TW'(TIMEOUT_CYCLES - 1)) begin
      st_nxt.tmo = '0;
      st_nxt.abort = 1'b1; // RULE13
    end else begin
      st_nxt.tmo = st_r.tmo + TW'(1);
    end
    // Synchronous reset loads power-on values.
    if (srst) begin
      st_nxt = '0;
      st_nxt.gen[G_RATE] = RST_RATE; // RULE11
      st_nxt.gen[G_LHI] = RST_HIGH; // RULE11
      st_nxt.gen[G_LTHM] = RST_HIGH; // RULE11
      st_nxt.gen[G_HYST] = RST_HYST; // RULE11
      st_nxt.gen[G_FILT] = RST_FILT; // RULE4 RULE6
      for (int ch = 0; ch < 2; ch++) begin
        st_nxt.rem[ch][R_HLH] = RST_HIGH; // RULE11
        st_nxt.rem[ch][R_THM] = RST_HIGH; // RULE11
      end
    end
  end

  // Registers the whole state.
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rd_data = st_r.rdat;
  assign bus_abort = st_r.abort;
  assign oneshot_start = st_r.shot;
  assign alert_n = !st_r.alert; // RULE14
  assign standby = st_r.gen[G_CFG1][CFG1_STBY_BIT];
  assign conv_rate = st_r.gen[G_RATE];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Run length of the channel being measured, before this measurement.
  logic [2:0] cur_cnt;
  always_comb begin
    cur_cnt = (meas_chan < 2'(NCH)) ? st_r.cnt[meas_chan] : 3'd0;
  end

  a_oneshot_pulse: assert property (@(posedge clock) disable iff (srst) // RULE1
    data_we && st_r.ptr == WR_ONESHOT && standby |=> oneshot_start ##1 !oneshot_start)
    else $error("one-shot strobe not a single pulse");
  a_oneshot_idle: assert property (@(posedge clock) disable iff (srst) // RULE2
    data_we && !meas_we && st_r.ptr == WR_ONESHOT |=> $stable(st_r.gen) && $stable(st_r.rem))
    else $error("one-shot write changed a register");
  a_filter_default: assert property (@(posedge clock) // RULE4
    srst |=> need == 3'd1 && alert_n && !st_r.gen[G_FILT][FILT_SCL_BIT])
    else $error("filter not one violation after reset");
  a_filter_max: assert property (@(posedge clock) disable iff (srst) // RULE5
    need <= 3'd4 && st_r.cnt[0] <= 3'd4)
    else $error("filter count above four");
  a_alert_wait: assert property (@(posedge clock) disable iff (srst) // RULE3
    $fell(alert_n) |-> $past(meas_we && meas_oor) && ($past(cur_cnt) + 3'd1) >= $past(need))
    else $error("alert before required count");
  a_mask_local: assert property (@(posedge clock) disable iff (srst) // RULE7
    meas_we && meas_chan == 2'd0 && st_r.gen[G_FILT][FILT_MASK_BIT] && alert_n |=> alert_n)
    else $error("masked local channel raised alert");
  a_lock_hold: assert property (@(posedge clock) disable iff (srst) // RULE16
    lock && !meas_we |=> $stable(st_r.gen) && $stable(st_r.rem))
    else $error("write landed while locked");
  a_sel_write: assert property (@(posedge clock) disable iff (srst) // RULE9
    data_we && !lock && st_r.ptr == RW_RSEL_OFH |=>
      st_r.rem[$past(st_r.gen[G_CFG1][CFG1_RSEL_BIT])][R_OFH] == $past(wdata))
    else $error("shared offset went to wrong channel");
  a_timeout_fire: assert property (@(posedge clock) disable iff (srst) // RULE13
    bus_abort |-> $past(stall) && $past(st_r.tmo) == TW'(TIMEOUT_CYCLES - 1))
    else $error("abort without full stall");
  a_alert_holds: assert property (@(posedge clock) disable iff (srst) // RULE14
    !alert_n && !alert_serviced |=> !alert_n)
    else $error("alert dropped without service");
  // Writes at the read address of a split register are dropped.
  a_split_refuse: assert property (@(posedge clock) disable iff (srst) // RULE8
    data_we && st_r.ptr == RD_LHI |=> $stable(st_r.gen[G_LHI]))
    else $error("write at read address landed");
  // The dedicated second-remote value address ignores the select bit.
  a_r2_read: assert property (@(posedge clock) disable iff (srst) // RULE10
    rd_req && st_r.ptr == RD_R2_VHI |=> rd_data == $past(st_r.rem[1][R_VHI]))
    else $error("dedicated read missed second remote");
  // With both timeouts off no transaction is ever abandoned.
  a_timeout_off: assert property (@(posedge clock) disable iff (srst) // RULE6
    !st_r.gen[G_FILT][FILT_SCL_BIT] && !st_r.gen[G_FILT][FILT_SDA_BIT] |=> !bus_abort)
    else $error("abort with timeouts disabled");
  // An in-limit result restarts that channel's run.
  a_run_restart: assert property (@(posedge clock) disable iff (srst) // RULE15
    meas_we && !meas_oor && meas_chan == 2'd1 |=> st_r.cnt[1] == 3'd0)
    else $error("in-limit result kept the run");
  // Local results land in the value register whatever the lock.
  a_value_update: assert property (@(posedge clock) disable iff (srst) // RULE16
    meas_we && meas_chan == 2'd0 |=> st_r.gen[G_LVAL] == $past(meas_hi))
    else $error("local value not stored");

  c_oneshot: cover property (@(posedge clock) disable iff (srst) oneshot_start);
  c_alert_four: cover property (@(posedge clock) disable iff (srst) $fell(alert_n) && need == 3'd4);
  c_abort: cover property (@(posedge clock) disable iff (srst) bus_abort);
  c_masked_local: cover property (@(posedge clock) disable iff (srst)
    meas_we && meas_oor && meas_chan == 2'd0 && st_r.gen[G_FILT][FILT_MASK_BIT]);
  c_lock_write: cover property (@(posedge clock) disable iff (srst) lock && data_we);

endmodule : tmrm_regbank
`default_nettype wire

// File: testbench/tmrm_host.sv
// Host model that drives the register pointer, data write and read strobes.
`default_nettype none
module tmrm_host (
  input wire logic clock,
  output logic ptr_we,
  output logic [7:0] ptr_wdata,
  output logic data_we,
  output logic [7:0] wdata,
  output logic rd_req,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobes rest low until a task runs.
  initial begin
    ptr_we = 1'b0;
    ptr_wdata = 8'h00;
    data_we = 1'b0;
    wdata = 8'h00;
    rd_req = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // A write sends the write address as pointer, then the data byte.
  // Released buses show the inverse so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    ptr_we = 1'b1;
    ptr_wdata = a;
    @(negedge clock);
    ptr_we = 1'b0;
    ptr_wdata = ~a;
    data_we = 1'b1;
    wdata = d;
    @(negedge clock);
    data_we = 1'b0;
    wdata = ~d;
  endtask : wr
  // A read sends the read address as pointer, then one read strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    ptr_we = 1'b1;
    ptr_wdata = a;
    @(negedge clock);
    ptr_we = 1'b0;
    ptr_wdata = ~a;
    rd_req = 1'b1;
    @(negedge clock);
    rd_req = 1'b0;
    d = rd_data;
  endtask : rd
endmodule : tmrm_host
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the thermal monitor register bank.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmrm_pkg::*;
  logic clock = 1'b0, srst = 1'b1, lock = 1'b0, meas_we = 1'b0, meas_oor = 1'b0;
  logic alert_serviced = 1'b0, bus_busy = 1'b0, scl_low = 1'b0, sda_low = 1'b0;
  logic [1:0] meas_chan = 2'd0;
  logic [7:0] meas_hi = 8'h00, meas_lo = 8'h00, status1_flags = 8'ha5, rd_data, conv_rate;
  logic ptr_we, data_we, rd_req, bus_abort, oneshot_start, alert_n, standby;
  logic [7:0] ptr_wdata, wdata;
  int n_mismatch = 0, tests_run = 0, n_os = 0, n_abort = 0;
  // A short timeout keeps the stall scenarios brief.
  tmrm_regbank #(.TIMEOUT_CYCLES(20), .MAKER_ID(8'h3c), .SILICON_REV(8'h02)) DUT (
    .clock(clock), .srst(srst), .ptr_we(ptr_we), .ptr_wdata(ptr_wdata),
    .data_we(data_we), .wdata(wdata), .rd_req(rd_req), .rd_data(rd_data), .lock(lock),
    .meas_we(meas_we), .meas_chan(meas_chan), .meas_hi(meas_hi), .meas_lo(meas_lo),
    .meas_oor(meas_oor), .status1_flags(status1_flags), .alert_serviced(alert_serviced),
    .bus_busy(bus_busy), .scl_low(scl_low), .sda_low(sda_low), .bus_abort(bus_abort),
    .oneshot_start(oneshot_start), .alert_n(alert_n), .standby(standby),
    .conv_rate(conv_rate));
  tmrm_host host (.clock(clock), .ptr_we(ptr_we), .ptr_wdata(ptr_wdata),
    .data_we(data_we), .wdata(wdata), .rd_req(rd_req), .rd_data(rd_data));
  // The clock toggles every 50 ns for a 100 ns period.
  always #50 clock = ~clock;
  // Pulse monitors count one-cycle outputs at each sampling edge.
  always @(posedge clock) begin
    if (oneshot_start === 1'b1) n_os++;
    if (bus_abort === 1'b1) n_abort++;
  end
  ////////////////////////////////////////////////////////////////////////
  // The one compare prints and counts any difference.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Reads one register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask : rchk
  // Waits a number of falling edges.
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // Delivers one measurement; the low byte is the inverse of the high byte.
  task automatic meas(input logic [1:0] c, input logic o, input logic [7:0] h);
    @(negedge clock);
    meas_we = 1'b1;
    meas_chan = c;
    meas_oor = o;
    meas_hi = h;
    meas_lo = ~h;
    @(negedge clock);
    meas_we = 1'b0;
  endtask : meas
  // Brings the local and first remote channels in limit, then services the alert.
  task automatic clear();
    meas(2'd0, 1'b0, 8'h00);
    meas(2'd1, 1'b0, 8'h00);
    alert_serviced = 1'b1;
    tick(1);
    alert_serviced = 1'b0;
    tick(1);
    chk({7'h00, alert_n}, 8'h01);
  endtask : clear
  ////////////////////////////////////////////////////////////////////////
  // Power-on values, identity, status pass-through and an unmapped read.
  task automatic t_reset();
    logic [7:0] ad [16] = '{RD_CFG1, RD_RATE, RD_LHI, RD_LLO, RD_RSEL_HLH, RD_RSEL_LLH,
      RW_RSEL_THM, RW_LTHM, RW_HYST, RW_FILT, RD_STAT2, RW_CFG2, RW_R2_HLH, RW_R2_THM,
      RD_R2_VHI, RD_LVAL};
    logic [7:0] ev [16] = '{8'h00, 8'h07, 8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55,
      8'h0a, 8'h01, 8'h00, 8'h00, 8'h55, 8'h55, 8'h00, 8'h00};
    chk(conv_rate, 8'h07);
    chk(rd_data, 8'h00);
    chk({7'h00, standby}, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    for (int i = 0; i < 16; i++) rchk(ad[i], ev[i]);
    rchk(RD_MAKER, 8'h3c);
    rchk(RD_STAT1, 8'ha5);
    rchk(8'h50, 8'h00);
  endtask : t_reset
  // Split addresses: writes land only at the write address.
  task automatic t_split();
    host.wr(WR_LHI, 8'h60);
    rchk(RD_LHI, 8'h60);
    host.wr(RD_LHI, 8'h33);
    rchk(RD_LHI, 8'h60);
    host.wr(WR_RATE, 8'h04);
    chk(conv_rate, 8'h04);
    rchk(RD_RATE, 8'h04);
  endtask : t_split
  // Shared remote addresses follow the select bit; dedicated ones never do.
  task automatic t_alias();
    host.wr(WR_CFG1, 8'h08);
    host.wr(RW_RSEL_OFH, 8'h3a);
    host.wr(RW_RSEL_THM, 8'h44);
    host.wr(WR_CFG1, 8'h00);
    rchk(RW_RSEL_OFH, 8'h00);
    rchk(RW_RSEL_THM, 8'h55);
    rchk(RW_R2_OFH, 8'h3a);
    rchk(RW_R2_THM, 8'h44);
    meas(2'd2, 1'b0, 8'h42);
    meas(2'd1, 1'b0, 8'h2b);
    rchk(RD_RSEL_VHI, 8'h2b);
    rchk(RD_R2_VHI, 8'h42);
    rchk(RD_R2_VLO, 8'hbd);
    host.wr(WR_CFG1, 8'h08);
    rchk(RD_RSEL_VHI, 8'h42);
    rchk(RD_RSEL_VLO, 8'hbd);
    rchk(RW_RSEL_OFH, 8'h3a);
    host.wr(WR_CFG1, 8'h00);
  endtask : t_alias
  // The strobe fires once per write in standby only, and keeps no data.
  task automatic t_oneshot();
    int base;
    base = n_os;
    host.wr(WR_ONESHOT, 8'hff);
    tick(2);
    chk(8'(n_os - base), 8'h00);
    host.wr(WR_CFG1, 8'h40);
    chk({7'h00, standby}, 8'h01);
    host.wr(WR_ONESHOT, 8'ha5);
    tick(2);
    chk(8'(n_os - base), 8'h01);
    rchk(RD_CFG1, 8'h40);
    host.wr(WR_CFG1, 8'h00);
  endtask : t_oneshot
  // Lock blocks host writes but not measurement values.
  task automatic t_lock();
    lock = 1'b1;
    host.wr(WR_LHI, 8'h11);
    rchk(RD_LHI, 8'h60);
    meas(2'd2, 1'b0, 8'h21);
    rchk(RD_R2_VHI, 8'h21);
    lock = 1'b0;
  endtask : t_lock
  // Each thermometer filter code, the run restart and the local mask.
  task automatic t_filter();
    logic [7:0] code [5] = '{8'h00, 8'h02, 8'h06, 8'h0e, 8'h0f};
    int need [5] = '{1, 2, 3, 4, 4};
    for (int i = 0; i < 5; i++) begin
      host.wr(RW_FILT, code[i]);
      repeat (need[i] - 1) meas(2'd1, 1'b1, 8'h70);
      tick(2);
      chk({7'h00, alert_n}, 8'h01);
      meas(2'd1, 1'b1, 8'h70);
      tick(1);
      chk({7'h00, alert_n}, 8'h00);
      clear();
    end
    host.wr(RW_FILT, 8'h06);
    meas(2'd1, 1'b1, 8'h70);
    meas(2'd1, 1'b1, 8'h70);
    meas(2'd1, 1'b0, 8'h20);
    meas(2'd1, 1'b1, 8'h70);
    meas(2'd1, 1'b1, 8'h70);
    tick(2);
    chk({7'h00, alert_n}, 8'h01);
    clear();
    host.wr(RW_FILT, 8'h20);
    meas(2'd0, 1'b1, 8'h70);
    tick(2);
    chk({7'h00, alert_n}, 8'h01);
    meas(2'd1, 1'b1, 8'h70);
    tick(1);
    chk({7'h00, alert_n}, 8'h00);
    clear();
    host.wr(RW_FILT, 8'h01);
  endtask : t_filter
  // Holds a stalled transaction for 30 cycles and counts the aborts.
  task automatic stall(input logic s, input logic d, input logic [7:0] e);
    int base;
    base = n_abort;
    bus_busy = 1'b1;
    scl_low = s;
    sda_low = d;
    tick(30);
    bus_busy = 1'b0;
    scl_low = 1'b0;
    sda_low = 1'b0;
    tick(2);
    chk(8'(n_abort - base), e);
  endtask : stall
  // The clock timeout enable watches only its own line; the data enable is checked only on its own line.
  task automatic t_timeout();
    stall(1'b1, 1'b1, 8'h00);
    host.wr(RW_FILT, 8'h80);
    stall(1'b1, 1'b0, 8'h01);
    stall(1'b0, 1'b1, 8'h00);
    host.wr(RW_FILT, 8'h40);
    stall(1'b0, 1'b1, 8'h01);
    host.wr(RW_FILT, 8'h01);
  endtask : t_timeout
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // Main sequence after three reset cycles.
  initial begin
    tick(3);
    srst = 1'b0;
    t_reset();
    t_split();
    t_alias();
    t_oneshot();
    t_lock();
    t_filter();
    t_timeout();
    conclude();
  end
  // A bounded watchdog cuts a hang short and counts it as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
endmodule : tb
`default_nettype wire
